// ---- hdl/cbo_pkg.sv ----
/*
 * Shared constants of the clock and buzzer output generator:
 * register map, field positions, reset values and divider layout.
 * Assumes a single 100 MHz main clock and a plain register port.
 */
package cbo_pkg;
    localparam int          ADDR_W        = 20;
    localparam int          DATA_W        = 8;
    localparam int          DIV_W         = 13;
    localparam int          SEL_W         = 3;
    // Register byte addresses
    localparam logic [19:0] ADDR_CKSEL    = 20'hfffa5;
    localparam logic [19:0] ADDR_REDIR    = 20'hfffa6;
    // Field positions inside the select and redirect registers
    localparam int          BIT_OE        = 7;
    localparam int          BIT_SEL_LO    = 0;
    localparam int          BIT_REDIR     = 0;
    // Reset values
    localparam logic [7:0]  CKSEL_RST     = 8'h00;
    localparam logic        REDIR_RST     = 1'b0;
    // Divider shift for each select code (output = main / 2^shift, main / 2 for shift 0)
    localparam logic [3:0]  SHIFT_TAB [8] = '{4'h0, 4'h1, 4'h2, 4'h3,
                                              4'h4, 4'hb, 4'hc, 4'hd};
    localparam logic [12:0] DIV_ZERO      = 13'h0000;
    localparam logic [12:0] DIV_ONE       = 13'h0001;
endpackage : cbo_pkg

// ---- hdl/cbo_prescaler.sv ----
/*
 * Free running prescaler of the main clock.
 * Gives only the DIV_W-bit count; the caller decodes from it a one-cycle
 * enable at each edge of the divided clock; ratio 1 toggles every cycle, handled by the caller.
 */
`timescale 1ns/1ps
module cbo_prescaler
    import cbo_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst,
    output logic [DIV_W-1:0]       o_count
);
    logic [DIV_W-1:0] count_q;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            count_q <= DIV_ZERO;
        end else begin
            count_q <= count_q + DIV_ONE;
        end
    end

    assign o_count = count_q;
endmodule : cbo_prescaler

// ---- hdl/cbo_top.sv ----
/*
 * Clock and buzzer output generator.
 * Holds the select register and the redirect bit, divides the main clock
 * and drives one of two pins with a glitch-free gated square wave.
 * Assumes a bus master on the same clock that never issues read and
 * write together, and port pads configured by software elsewhere.
 */
`timescale 1ns/1ps

module cbo_top
    import cbo_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic [DATA_W-1:0] i_wmask,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [DATA_W-1:0] o_rdata,
    output logic                   o_pin_main,
    output logic                   o_pin_alt,
    output logic                   o_running
);
    import cbo_pkg::*;

    logic             oe_q;
    logic [SEL_W-1:0] sel_q;
    logic             redir_q;
    logic [7:0]       rdata_q;
    logic             run_q;
    logic             wave_q;
    logic             pin_main_q;
    logic             pin_alt_q;
    logic [DIV_W-1:0] count;

    function automatic logic [7:0] merge(input logic [7:0] old_v,
                                         input logic [7:0] new_v,
                                         input logic [7:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction : merge

    wire         hit_cksel = (i_addr == ADDR_CKSEL);
    wire         hit_redir = (i_addr == ADDR_REDIR);
    wire [7:0]   cksel_now = {oe_q, 4'h0, sel_q};
    wire [7:0]   cksel_new = merge(cksel_now, i_wdata, i_wmask);
    wire [7:0]   redir_new = merge({7'h00, redir_q}, i_wdata, i_wmask);
    wire [7:0]   rd_mux    = hit_cksel ? cksel_now :
                             hit_redir ? {7'h00, redir_q} : 8'h00;
    wire [3:0]   shift     = SHIFT_TAB[sel_q];
    // Divided wave phase: bit (shift-1) of the prescaler, or a toggle for /1
    wire         div_bit   = (shift == 4'h0) ? 1'b0 : count[shift - 4'h1];
    wire         tick_mask = (shift == 4'h0) ? 1'b1 :
                             ((count & ((DIV_ONE << (shift - 4'h1)) - DIV_ONE))
                              == ((DIV_ONE << (shift - 4'h1)) - DIV_ONE));
    wire         next_wave = (shift == 4'h0) ? ~wave_q : ~div_bit;
    // change at end of low half
    // Only where a high half starts next, so run and wave rise together
    wire         at_low    = ~wave_q & tick_mask & next_wave;

    cbo_prescaler u_pre (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .o_count   (count)
    );

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            oe_q    <= CKSEL_RST[BIT_OE];
            sel_q   <= CKSEL_RST[SEL_W-1:0];
            redir_q <= REDIR_RST;
        end else if (i_wr && hit_cksel) begin
            oe_q    <= cksel_new[BIT_OE];
            sel_q   <= cksel_new[BIT_SEL_LO +: SEL_W];
        end else if (i_wr && hit_redir) begin
            redir_q <= redir_new[BIT_REDIR];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= i_rd ? rd_mux : 8'h00;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            run_q  <= 1'b0;
            wave_q <= 1'b0;
        end else if (tick_mask) begin
            if (at_low) begin
                run_q <= oe_q;
            end
            wave_q <= (at_low ? oe_q : run_q) & next_wave;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_main_q <= 1'b0;
            pin_alt_q  <= 1'b0;
        end else begin
            pin_main_q <= wave_q & ~redir_q;
            pin_alt_q  <= wave_q & redir_q;
        end
    end

    assign o_rdata    = rdata_q;
    assign o_pin_main = pin_main_q;
    assign o_pin_alt  = pin_alt_q;
    assign o_running  = run_q;
endmodule : cbo_top

// ---- sim/cbo_checker.sv ----
/* Port assertions for cbo_top.
   Assumes a bind onto cbo_top, one clock. */
`timescale 1ns/1ps
module cbo_checker
    import cbo_pkg::*;
(
    input wire logic              i_ref_clk,
    input wire logic              i_rst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic              i_rd,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic              o_pin_main,
    input wire logic              o_pin_alt,
    input wire logic              o_running
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    a_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("rdata");
    a_rsvd_zero: assert property ($past(i_rd) |-> o_rdata[6:3] == 4'h0) else $error("rsvd");
    a_unmap_zero: assert property ($past(i_rd) && $past(i_addr) != ADDR_CKSEL
        && $past(i_addr) != ADDR_REDIR |-> o_rdata == 8'h00) else $error("unmap");
    a_main_gated: assert property (o_pin_main |-> $past(o_running)) else $error("main");
    a_alt_gated: assert property (o_pin_alt |-> $past(o_running)) else $error("alt");
    a_one_pin: assert property (!(o_pin_main && o_pin_alt)) else $error("two pins");
    a_start_pulse: assert property ($rose(o_running) |=> o_pin_main || o_pin_alt) else $error("start");
    a_stop_low: assert property ($fell(o_running) |=> !o_pin_main && !o_pin_alt) else $error("stop");
endmodule : cbo_checker
bind cbo_top cbo_checker cbo_checker_inst (.*);

// ---- sim/cbo_pin_load.sv ----
/* Load on the output pin: width of each high pulse.
   Assumes the pin sampled on the main clock. */
`timescale 1ns/1ps
module cbo_pin_load (
    input  wire logic i_ref_clk,
    input  wire logic i_pin,
    output int        o_width
);
    localparam logic port_direction           = 1'b0;
    localparam logic port_analog_digital_mode = 1'b0;
    wire             pad = i_pin & ~port_direction & ~port_analog_digital_mode;
    int run = 0;
    always @(posedge i_ref_clk) begin
        if (pad) run <= run + 1;
        else if (run != 0) begin
            o_width <= run;
            run <= 0;
        end
    end
endmodule : cbo_pin_load

// ---- sim/cbo_top_tb.sv ----
/* Bench for cbo_top: registers, all ratios, redirect, reset.
   Assumes cbo_checker bound and cbo_pin_load on the pins. */
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fail_count++; \
    $display("mismatch %s exp %0h got %0h", n, e, a); end end
module cbo_top_tb;
    import cbo_pkg::*;
    logic        i_ref_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0;
    logic [19:0] i_addr = 0;
    logic [7:0]  i_wdata = 0, i_wmask = 0, o_rdata;
    logic        o_pin_main, o_pin_alt, o_running;
    int          fail_count = 0, checks = 0, width, cyc = 0, s;
    cbo_top cbo_top_inst (.*);
    cbo_pin_load cbo_pin_load_inst (.i_ref_clk(i_ref_clk), .i_pin(o_pin_main | o_pin_alt),
        .o_width(width));
    initial forever #5 i_ref_clk = ~i_ref_clk;
    task automatic wr(input logic [19:0] a, input logic [7:0] d, m);
        @(posedge i_ref_clk);
        {i_wr, i_addr, i_wdata, i_wmask} <= {1'b1, a, d, m};
        @(posedge i_ref_clk);
        i_wr <= 0;
    endtask : wr
    task automatic rd(input logic [19:0] a, input logic [7:0] e);
        @(posedge i_ref_clk);
        {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_ref_clk);
        i_rd <= 0;
        #1 `CHK("rdata", e, o_rdata)
    endtask : rd
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 90000) begin fail_count++; final_report(); end
    end
    initial begin
        repeat (12) @(posedge i_ref_clk);
        i_rst <= 0;
        rd(ADDR_CKSEL, CKSEL_RST);
        wr(ADDR_CKSEL, 8'h79, 8'hff);
        rd(ADDR_CKSEL, 8'h01);
        wr(ADDR_CKSEL, 8'h80, 8'h80);
        rd(ADDR_CKSEL, 8'h81);
        wr(ADDR_CKSEL, 8'h00, 8'h80);
        rd(ADDR_CKSEL, 8'h01);
        rd(20'h00000, 8'h00);
        $display("test registers done");
        for (int c = 0; c < 8; c++) begin
            s = SHIFT_TAB[c];
            wr(ADDR_CKSEL, c[7:0], 8'hff);
            wr(ADDR_CKSEL, 8'h80 | c[7:0], 8'hff);
            repeat ((2 << s) + 8) @(posedge i_ref_clk);
            #1;
            `CHK("running", 1'b1, o_running)
            `CHK("width", (s == 0) ? 1 : 1 << (s - 1), width)
            wr(ADDR_CKSEL, c[7:0], 8'hff);
            repeat ((2 << s) + 4) @(posedge i_ref_clk);
            #1;
            `CHK("stopped", 1'b0, o_running)
            `CHK("idle pin", 1'b0, o_pin_main | o_pin_alt)
        end
        $display("test ratios done");
        wr(ADDR_REDIR, 8'h01, 8'hff);
        wr(ADDR_CKSEL, 8'h02, 8'hff);
        wr(ADDR_CKSEL, 8'h82, 8'hff);
        repeat (20) @(posedge i_ref_clk);
        #1;
        `CHK("main", 1'b0, o_pin_main)
        `CHK("alt width", 2, width)
        rd(ADDR_REDIR, 8'h01);
        i_rst <= 1;
        @(posedge i_ref_clk);
        i_rst <= 0;
        rd(ADDR_CKSEL, 8'h00);
        rd(ADDR_REDIR, 8'h00);
        `CHK("reset run", 1'b0, o_running)
        $display("test redirect done");
        final_report();
    end
endmodule : cbo_top_tb
